// ===== design/flc_defines.svh
// register map, field positions, reset values and timing figures of the fan table control
`ifndef FLC_DEFINES_SVH
`define FLC_DEFINES_SVH
`define FLC_ADDR_FAN_SETUP 8'h45
`define FLC_ADDR_STARTUP 8'h46
`define FLC_ADDR_PUSHED1 8'h48
`define FLC_ADDR_PUSHED2 8'h49
`define FLC_ADDR_STATUS 8'h4a
`define FLC_ADDR_RESULT 8'h4b
`define FLC_ADDR_TABLE 8'h50
`define FLC_ADDR_LUT_BASE 8'h80
`define FLC_LUT_ENTRIES 8'd40
`define FLC_LUT_OUT_BASE 6'd32
`define FLC_RST_FAN_SETUP 8'h2b
`define FLC_RST_STARTUP 8'h0a
`define FLC_RST_TABLE 8'h00
`define FLC_RST_PUSHED 8'h00
`define FLC_FS_LOOP_ON 7
`define FLC_FS_RANGE_LO 5
`define FLC_FS_EDGES_LO 3
`define FLC_FS_UPDATE_LO 0
`define FLC_SU_FAIL_LO 6
`define FLC_SU_SKIP_KICK 5
`define FLC_SU_LEVEL_LO 2
`define FLC_SU_DUR_LO 0
`define FLC_TB_P1_FMT 7
`define FLC_TB_P2_FMT 6
`define FLC_TB_ARMED 5
`define FLC_TB_DRIVE_MODE 4
`define FLC_TB_COL3_LO 2
`define FLC_TB_COL4_LO 0
`define FLC_SENSOR_REF_C 8'd100
`define FLC_MIN_RPM_BASE 16'd500
`define FLC_MCLK_KHZ 10000
`define FLC_UPDATE_UNIT_MS 100
`define FLC_SPIN_BASE_MS 250
`define FLC_FULL_DUTY 7'd100
`define FLC_LEVEL_BASE 7'd30
`define FLC_LEVEL_STEP 7'd5
`define FLC_FAIL_BASE 7'd16
`define FLC_NO_HIT_TACH 8'hff
`define FLC_NO_HIT_DRIVE 8'h00
`endif

// ===== design/flc_pkg.sv
// types shared by the fan table control modules
package flc_pkg;
    typedef enum logic [1:0] {FLC_SRC_A, FLC_SRC_B, FLC_SRC_PUSHED, FLC_SRC_SPARE} flc_src_t;
    typedef enum {FLC_SP_IDLE, FLC_SP_KICK, FLC_SP_HOLD} flc_spin_t;
    typedef logic [7:0] flc_byte_t;
endpackage

// ===== design/flc_mem_if.sv
// write and read port of the lookup table storage
`timescale 1ns/10ps
`default_nettype none
interface flc_mem_if;
    logic we;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [5:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface // flc_mem_if
`default_nettype wire

// ===== design/flc_lut_mem.sv
// lookup table storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module flc_lut_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 40
) (
    input wire logic mclk,
    flc_mem_if.mem m
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge mclk)
    begin
        if (m.we)
        begin
            store[m.waddr] <= m.wdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        m.rdata <= store[m.raddr];
    end
endmodule // flc_lut_mem
`default_nettype wire

// ===== design/flc_top.sv
// fan lookup table configuration, table scan and speed loop parameters
`timescale 1ns/10ps
`default_nettype none
`include "flc_defines.svh"
module flc_top #(
    parameter int UPDATE_UNIT_CYC = `FLC_UPDATE_UNIT_MS * `FLC_MCLK_KHZ,
    parameter int SPIN_BASE_CYC = `FLC_SPIN_BASE_MS * `FLC_MCLK_KHZ
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire flc_pkg::flc_byte_t reg_wdata,
    output flc_pkg::flc_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire flc_pkg::flc_byte_t temp_ext1,
    input wire flc_pkg::flc_byte_t temp_ext2,
    input wire flc_pkg::flc_byte_t temp_ext3,
    input wire flc_pkg::flc_byte_t shutdown_threshold_input,
    input wire flc_pkg::flc_byte_t temp_internal,
    input wire flc_pkg::flc_byte_t temp_ext4,
    input wire logic spin_request,
    input wire logic fan_below_min,
    output flc_pkg::flc_byte_t lut_setting,
    output logic lut_valid,
    output logic lut_tach_mode,
    output logic speed_loop_on,
    output logic [15:0] min_rpm,
    output logic [2:0] fan_poles,
    output logic update_tick,
    output logic spin_active,
    output logic [6:0] spin_drive_pct,
    output logic drive_fail
);
    import flc_pkg::*;

    flc_mem_if mif ();
    flc_lut_mem #(.WIDTH(8), .DEPTH(40)) u_mem (.mclk(mclk), .m(mif.mem));

    flc_byte_t fan_setup_r, startup_r, table_r, pushed1_r, pushed2_r;
    flc_byte_t col_in [4];
    flc_byte_t col_sel_r [4];
    logic [3:0] col_hit_r;
    logic [2:0] step_r, sub_r, rd_sub_r;
    logic rd_valid_r, rd_last_r, fin_r;
    flc_byte_t out_hold_r, result_nxt;
    logic armed, lut_wr;
    logic [7:0] lut_off;
    logic [31:0] upd_cnt_r, upd_limit;
    logic [6:0] stall_cnt_r;
    flc_spin_t spin_r;
    logic [31:0] spin_cnt_r, spin_total;

    function automatic flc_byte_t flc_xlat(flc_byte_t v, logic fmt);
        // sensor format holds 100 minus the processor temperature
        if (!fmt)
            return v;
        else if (v > `FLC_SENSOR_REF_C)
            return 8'h00;
        else
            return `FLC_SENSOR_REF_C - v;
    endfunction

    function automatic flc_byte_t flc_pick(flc_byte_t a, flc_byte_t b, logic tach);
        // keep the entry asking the fan for more effort
        if (tach)
            return (b < a) ? b : a;
        else
            return (b > a) ? b : a;
    endfunction

    assign armed = table_r[`FLC_TB_ARMED];
    assign lut_off = reg_addr - `FLC_ADDR_LUT_BASE;
    assign lut_wr = reg_wr && reg_addr >= `FLC_ADDR_LUT_BASE && lut_off < `FLC_LUT_ENTRIES;

    assign mif.we = lut_wr && !armed;
    assign mif.waddr = lut_off[5:0];
    assign mif.wdata = reg_wdata;

    // host register writes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fan_setup_r <= `FLC_RST_FAN_SETUP;
            startup_r <= `FLC_RST_STARTUP;
            table_r <= `FLC_RST_TABLE;
            pushed1_r <= `FLC_RST_PUSHED;
            pushed2_r <= `FLC_RST_PUSHED;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `FLC_ADDR_FAN_SETUP: fan_setup_r <= reg_wdata;
                `FLC_ADDR_STARTUP: startup_r <= reg_wdata;
                `FLC_ADDR_TABLE: table_r <= reg_wdata;
                `FLC_ADDR_PUSHED1: pushed1_r <= reg_wdata;
                `FLC_ADDR_PUSHED2: pushed2_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // host register reads, answer one cycle later
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `FLC_ADDR_FAN_SETUP: reg_rdata <= fan_setup_r;
                    `FLC_ADDR_STARTUP: reg_rdata <= startup_r;
                    `FLC_ADDR_TABLE: reg_rdata <= table_r;
                    `FLC_ADDR_PUSHED1: reg_rdata <= pushed1_r;
                    `FLC_ADDR_PUSHED2: reg_rdata <= pushed2_r;
                    `FLC_ADDR_STATUS: reg_rdata <= {5'h00, drive_fail, spin_active, lut_valid};
                    `FLC_ADDR_RESULT: reg_rdata <= lut_setting;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // column inputs
    always_comb
    begin
        col_in[0] = temp_ext1;
        col_in[1] = temp_ext2;
        // format flags in bits 7 and 6
        unique case (flc_src_t'(table_r[`FLC_TB_COL3_LO +: 2]))
            FLC_SRC_B: col_in[2] = shutdown_threshold_input;
            FLC_SRC_PUSHED: col_in[2] = flc_xlat(pushed1_r, table_r[`FLC_TB_P1_FMT]);
            default: col_in[2] = temp_ext3;
        endcase
        unique case (flc_src_t'(table_r[`FLC_TB_COL4_LO +: 2]))
            FLC_SRC_B: col_in[3] = temp_ext4;
            FLC_SRC_PUSHED: col_in[3] = flc_xlat(pushed2_r, table_r[`FLC_TB_P2_FMT]);
            default: col_in[3] = temp_internal;
        endcase
    end

    // table scan: per step the entry, then four thresholds
    assign mif.raddr = (sub_r == 3'd0) ? (`FLC_LUT_OUT_BASE + {3'd0, step_r})
                                       : {1'b0, sub_r[1:0] - 2'd1, step_r};

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            step_r <= 3'd0;
            sub_r <= 3'd0;
            rd_sub_r <= 3'd0;
            rd_valid_r <= 1'b0;
            rd_last_r <= 1'b0;
        end
        else if (!armed)
        begin
            step_r <= 3'd0;
            sub_r <= 3'd0;
            rd_valid_r <= 1'b0;
            rd_last_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= 1'b1;
            rd_sub_r <= sub_r;
            rd_last_r <= (step_r == 3'd7) && (sub_r == 3'd4);
            if (sub_r == 3'd4)
            begin
                sub_r <= 3'd0;
                step_r <= step_r + 3'd1;
            end
            else
            begin
                sub_r <= sub_r + 3'd1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            out_hold_r <= 8'h00;
            col_hit_r <= 4'h0;
            fin_r <= 1'b0;
            for (int c = 0; c < 4; c++)
                col_sel_r[c] <= 8'h00;
        end
        else
        begin
            fin_r <= rd_valid_r && rd_last_r && armed;
            if (fin_r || !armed)
                col_hit_r <= 4'h0;
            if (rd_valid_r && armed)
            begin
                if (rd_sub_r == 3'd0)
                    out_hold_r <= mif.rdata;
                else
                begin
                    for (int c = 0; c < 4; c++)
                    begin
                        if (rd_sub_r == 3'(c + 1) && col_in[c] >= mif.rdata)
                        begin
                            col_sel_r[c] <= out_hold_r;
                            col_hit_r[c] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // fold columns to most demanding entry
    always_comb
    begin
        result_nxt = lut_tach_mode ? `FLC_NO_HIT_TACH : `FLC_NO_HIT_DRIVE;
        for (int c = 0; c < 4; c++)
            if (col_hit_r[c])
                result_nxt = flc_pick(result_nxt, col_sel_r[c], lut_tach_mode);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lut_setting <= 8'h00;
            lut_valid <= 1'b0;
            lut_tach_mode <= 1'b1;
        end
        else
        begin
            // drive-mode bit clear selects tach targets
            lut_tach_mode <= !table_r[`FLC_TB_DRIVE_MODE];
            if (!armed)
                lut_valid <= 1'b0;
            else if (fin_r)
            begin
                lut_valid <= 1'b1;
                lut_setting <= result_nxt;
            end
        end
    end

    // speed loop parameters
    assign upd_limit = 32'(UPDATE_UNIT_CYC) * 32'(fan_setup_r[`FLC_FS_UPDATE_LO +: 3] + 3'd1);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            speed_loop_on <= 1'b0;
            min_rpm <= 16'h0000;
            fan_poles <= 3'd0;
        end
        else
        begin
            speed_loop_on <= fan_setup_r[`FLC_FS_LOOP_ON];
            // minimum speed doubles per range code
            min_rpm <= `FLC_MIN_RPM_BASE << fan_setup_r[`FLC_FS_RANGE_LO +: 2];
            fan_poles <= {1'b0, fan_setup_r[`FLC_FS_EDGES_LO +: 2]} + 3'd1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            upd_cnt_r <= 32'h0;
            update_tick <= 1'b0;
        end
        else if (!fan_setup_r[`FLC_FS_LOOP_ON] || upd_cnt_r >= upd_limit - 32'h1)
        begin
            upd_cnt_r <= 32'h0;
            update_tick <= fan_setup_r[`FLC_FS_LOOP_ON];
        end
        else
        begin
            upd_cnt_r <= upd_cnt_r + 32'h1;
            update_tick <= 1'b0;
        end
    end

    // stall detection off when code zero
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stall_cnt_r <= 7'd0;
            drive_fail <= 1'b0;
        end
        else
        begin
            if (startup_r[`FLC_SU_FAIL_LO +: 2] == 2'b00 || !fan_below_min)
                stall_cnt_r <= 7'd0;
            else if (update_tick && stall_cnt_r != 7'h7f)
                stall_cnt_r <= stall_cnt_r + 7'd1;
            if (stall_cnt_r >= (`FLC_FAIL_BASE << (startup_r[`FLC_SU_FAIL_LO +: 2] - 2'd1))
                && startup_r[`FLC_SU_FAIL_LO +: 2] != 2'b00)
                drive_fail <= 1'b1;
            else if (reg_rd && reg_addr == `FLC_ADDR_STATUS)
                drive_fail <= 1'b0;
        end
    end

    // total spin time doubles per code
    assign spin_total = 32'(SPIN_BASE_CYC) << startup_r[`FLC_SU_DUR_LO +: 2];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            spin_r <= FLC_SP_IDLE;
            spin_cnt_r <= 32'h0;
            spin_active <= 1'b0;
            spin_drive_pct <= 7'd0;
        end
        else
        begin
            unique case (spin_r)
                FLC_SP_IDLE:
                begin
                    if (spin_request)
                    begin
                        if (!startup_r[`FLC_SU_SKIP_KICK])
                        begin
                            spin_r <= FLC_SP_KICK;
                            spin_cnt_r <= (spin_total >> 2) - 32'h1;
                        end
                        else
                        begin
                            spin_r <= FLC_SP_HOLD;
                            spin_cnt_r <= spin_total - (spin_total >> 2) - 32'h1;
                        end
                    end
                end
                FLC_SP_KICK:
                begin
                    if (spin_cnt_r == 32'h0)
                    begin
                        spin_r <= FLC_SP_HOLD;
                        spin_cnt_r <= spin_total - (spin_total >> 2) - 32'h1;
                    end
                    else
                        spin_cnt_r <= spin_cnt_r - 32'h1;
                end
                FLC_SP_HOLD:
                begin
                    if (spin_cnt_r == 32'h0)
                        spin_r <= FLC_SP_IDLE;
                    else
                        spin_cnt_r <= spin_cnt_r - 32'h1;
                end
            endcase
            spin_active <= spin_r != FLC_SP_IDLE;
            spin_drive_pct <= (spin_r == FLC_SP_KICK) ? `FLC_FULL_DUTY
                : (spin_r == FLC_SP_HOLD)
                    ? `FLC_LEVEL_BASE + `FLC_LEVEL_STEP * {4'd0, startup_r[`FLC_SU_LEVEL_LO +: 3]}
                    : 7'd0;
        end
    end

    a_pushed_xlat: assert property (@(posedge mclk) disable iff (rst)
        table_r[3:2] == 2'b10 && table_r[7] && pushed1_r <= 8'd100
        |-> col_in[2] == 8'd100 - pushed1_r) else $error("pushed one not translated");
    a_col4_pushed: assert property (@(posedge mclk) disable iff (rst)
        table_r[1:0] == 2'b10 && !table_r[6] |-> col_in[3] == pushed2_r)
        else $error("column four source wrong");
    a_unarmed_idle: assert property (@(posedge mclk) disable iff (rst)
        !armed ##1 !armed |-> !lut_valid && !fin_r) else $error("table active unarmed");
    a_tach_mode: assert property (@(posedge mclk) disable iff (rst)
        $stable(table_r) |-> lut_tach_mode == !table_r[4]) else $error("tach mode mismatch");
    a_min_select: assert property (@(posedge mclk) disable iff (rst)
        armed && fin_r && col_hit_r[0] && lut_tach_mode |=> lut_setting <= $past(col_sel_r[0]))
        else $error("result not smallest target");
    a_step_hit: assert property (@(posedge mclk) disable iff (rst)
        armed && rd_valid_r && rd_sub_r == 3'd1 && col_in[0] >= mif.rdata && !fin_r
        |=> col_hit_r[0] && col_sel_r[0] == $past(out_hold_r)) else $error("met step lost");
    a_loop_off: assert property (@(posedge mclk) disable iff (rst)
        !fan_setup_r[7] |=> !update_tick) else $error("tick while loop off");
    a_upd_period: assert property (@(posedge mclk) disable iff (rst)
        update_tick && $past(fan_setup_r[7]) && $stable(fan_setup_r)
        |-> $past(upd_cnt_r) == upd_limit - 32'h1) else $error("update period wrong");
    a_fail_off: assert property (@(posedge mclk) disable iff (rst)
        startup_r[7:6] == 2'b00 |=> stall_cnt_r == 7'd0) else $error("stall count while off");
    a_kick_start: assert property (@(posedge mclk) disable iff (rst)
        spin_r == FLC_SP_IDLE && spin_request && !startup_r[5]
        |=> spin_r == FLC_SP_KICK && spin_cnt_r == (spin_total >> 2) - 32'h1 ##1
        spin_drive_pct == 7'd100) else $error("kick not started");
    a_hold_level: assert property (@(posedge mclk) disable iff (rst)
        spin_r == FLC_SP_HOLD && startup_r[4:2] == 3'b010 && $stable(startup_r)
        |=> spin_drive_pct == 7'd40) else $error("hold level wrong");
    a_spin_total: assert property (@(posedge mclk) disable iff (rst)
        spin_r == FLC_SP_KICK && spin_cnt_r == 32'h0
        |=> spin_r == FLC_SP_HOLD && spin_cnt_r == spin_total - (spin_total >> 2) - 32'h1)
        else $error("hold time wrong");
endmodule // flc_top
`default_nettype wire

// ===== bench/flc_fan_model.sv
// behavioural fan and temperature channels facing the table control
`timescale 1ns/10ps
`default_nettype none
module flc_fan_model
    import flc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] scene,
    input wire logic stall,
    output flc_byte_t ext1,
    output flc_byte_t ext2,
    output flc_byte_t ext3,
    output flc_byte_t thresh,
    output flc_byte_t internal,
    output flc_byte_t ext4,
    output logic below_min
);
    // unused channels read as a cold 0 degrees so a wrong source never hits a step
    assign ext3 = 8'h00;
    assign thresh = 8'h00;
    assign internal = 8'h00;
    assign ext4 = 8'h00;
    // measured temperatures per scene, stall only when commanded
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ext1 <= 8'h00;
            ext2 <= 8'h00;
            below_min <= 1'h0;
        end
        else
        begin
            ext1 <= 8'h4b;
            ext2 <= (scene == 2'h0) ? 8'h4b : (scene == 2'h1) ? 8'h5a : 8'h61;
            below_min <= stall;
        end
    end
endmodule // flc_fan_model
`default_nettype wire

// ===== bench/flc_top_tb.sv
// self-checking bench of the fan table control
`timescale 1ns/10ps
`default_nettype none
`include "flc_defines.svh"
module flc_top_tb;
    import flc_pkg::*;
    localparam int UNIT = 10;
    localparam int SPIN = 8;
    logic mclk, rst, reg_wr, reg_rd, spin_request, stall, reg_rvalid, lut_valid;
    logic lut_tach_mode, speed_loop_on, update_tick, spin_active, drive_fail, fan_below_min;
    logic [7:0] reg_addr;
    logic [1:0] scene;
    flc_byte_t reg_wdata, reg_rdata, lut_setting, t1, t2, t3, tv, ti, t4;
    logic [15:0] min_rpm;
    logic [2:0] fan_poles;
    logic [6:0] spin_drive_pct;
    int bad_count, cmp_count, n_kick, n_hold;
    logic [319:0] lut_img =
        320'h2328323c46505a64_414b555a5f64696e_32373c41464b5055_282d32373c415064_efa37a62523d3129;
    flc_byte_t p1 [3] = '{8'h23, 8'h0f, 8'h1e};
    flc_byte_t p2 [3] = '{8'h32, 8'h14, 8'h17};
    flc_byte_t ex [3] = '{8'h52, 8'h29, 8'h3d};

    flc_top #(.UPDATE_UNIT_CYC(UNIT), .SPIN_BASE_CYC(SPIN)) DUT (.mclk(mclk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temp_ext1(t1), .temp_ext2(t2),
        .temp_ext3(t3), .shutdown_threshold_input(tv), .temp_internal(ti), .temp_ext4(t4),
        .spin_request(spin_request), .fan_below_min(fan_below_min), .lut_setting(lut_setting),
        .lut_valid(lut_valid), .lut_tach_mode(lut_tach_mode), .speed_loop_on(speed_loop_on),
        .min_rpm(min_rpm), .fan_poles(fan_poles), .update_tick(update_tick),
        .spin_active(spin_active), .spin_drive_pct(spin_drive_pct), .drive_fail(drive_fail));

    flc_fan_model FAN (.mclk(mclk), .rst(rst), .scene(scene), .stall(stall), .ext1(t1),
        .ext2(t2), .ext3(t3), .thresh(tv), .internal(ti), .ext4(t4), .below_min(fan_below_min));

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input flc_byte_t d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input flc_byte_t exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk("read valid", reg_rvalid, 1'h1);
        chk(what, reg_rdata, exp);
    endtask

    // bounded wait: 0 table result, 1 update tick, 2 spin-up busy
    task automatic wait_hi(input int which, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge mclk);
            #1;
            if ((which == 0 && lut_valid === 1'h1) || (which == 1 && update_tick === 1'h1)
                || (which == 2 && spin_active === 1'h1))
                return;
        end
        bad_count++;
        $display("unexpected wait %0d expected event seen timeout", which);
        end_of_test();
    endtask

    task automatic put(input int s);
        scene <= 2'(s);
        wr(`FLC_ADDR_PUSHED1, p1[s]);
        wr(`FLC_ADDR_PUSHED2, p2[s]);
    endtask

    // a pass in flight may mix settings, so let two full passes go by
    task automatic scan(input flc_byte_t cfg, input flc_byte_t exp);
        wr(`FLC_ADDR_TABLE, cfg);
        wait_hi(0, 100);
        repeat (85) @(posedge mclk);
        #1;
        chk("table result", lut_setting, exp);
    endtask

    task automatic spin(input int exp_kick);
        @(posedge mclk);
        spin_request <= 1'h1;
        @(posedge mclk);
        spin_request <= 1'h0;
        wait_hi(2, 10);
        n_kick = 0;
        n_hold = 0;
        for (int i = 0; i < 200 && spin_active === 1'h1; i++)
        begin
            if (spin_drive_pct === 7'h64)
                n_kick++;
            if (spin_drive_pct === 7'h28)
                n_hold++;
            @(posedge mclk);
            #1;
        end
        chk("kick cycles", 16'(n_kick), 16'(exp_kick));
        chk("hold cycles", 16'(n_hold), 16'(3 * SPIN));
    endtask

    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        rst = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        spin_request = 1'h0;
        stall = 1'h0;
        scene = 2'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        rdc("fan setup", `FLC_ADDR_FAN_SETUP, `FLC_RST_FAN_SETUP);
        rdc("startup", `FLC_ADDR_STARTUP, `FLC_RST_STARTUP);
        rdc("table setup", `FLC_ADDR_TABLE, `FLC_RST_TABLE);
        rdc("unmapped", 8'h7f, 8'h00);
        chk("min rpm", min_rpm, 16'h03e8);
        chk("poles", fan_poles, 3'h2);
        chk("tach mode", lut_tach_mode, 1'h1);
        chk("loop on", speed_loop_on, 1'h0);
        wr(`FLC_ADDR_FAN_SETUP, 8'hab);
        repeat (2) @(posedge mclk);
        #1;
        chk("loop on", speed_loop_on, 1'h1);
        wait_hi(1, 100);
        for (n_kick = 1; n_kick < 100; n_kick++)
        begin
            @(posedge mclk);
            #1;
            if (update_tick === 1'h1)
                break;
        end
        chk("update period", 16'(n_kick), 16'(4 * UNIT));
        for (int i = 0; i < 40; i++)
            wr(`FLC_ADDR_LUT_BASE + 8'(i), lut_img[319 - 8 * i -: 8]);
        chk("valid unarmed", lut_valid, 1'h0);
        for (int s = 0; s < 3; s++)
        begin
            put(s);
            scan(8'hea, ex[s]);
        end
        wr(`FLC_ADDR_LUT_BASE + 8'h20, 8'h01);
        scan(8'hea, 8'h3d);
        scan(8'h2a, 8'h52);
        put(1);
        scan(8'he0, 8'h52);
        scan(8'hfa, 8'h62);
        rdc("result", `FLC_ADDR_RESULT, 8'h62);
        chk("tach mode", lut_tach_mode, 1'h0);
        wr(`FLC_ADDR_TABLE, 8'h00);
        repeat (3) @(posedge mclk);
        #1;
        chk("valid disarmed", lut_valid, 1'h0);
        spin(SPIN);
        wr(`FLC_ADDR_STARTUP, 8'h2a);
        spin(0);
        stall <= 1'h1;
        wr(`FLC_ADDR_STARTUP, 8'h0a);
        repeat (720) @(posedge mclk);
        #1;
        chk("fail off", drive_fail, 1'h0);
        wr(`FLC_ADDR_STARTUP, 8'h4a);
        repeat (720) @(posedge mclk);
        #1;
        chk("fail on", drive_fail, 1'h1);
        rdc("status", `FLC_ADDR_STATUS, 8'h04);
        end_of_test();
    end
endmodule // flc_top_tb
`default_nettype wire
